// ===== hw/maint_trap_regs.vh
// Constants for the maintenance trap and test panel block.
// Assumes a 32-bit APB slave on pclk, byte addresses word aligned.
`ifndef MAINT_TRAP_REGS_VH
`define MAINT_TRAP_REGS_VH

// ==============================
// Register byte offsets
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_MASK        12'h008
`define OFS_TRAPADDR    12'h00c
`define OFS_DIAGSW_LO   12'h010
`define OFS_DIAGSW_HI   12'h014
`define OFS_INSTR       12'h018
`define OFS_MATCH_ADDR  12'h01c
`define OFS_ERRCODE     12'h020
`define OFS_LOG_DATA    12'h024

// ==============================
// Control field positions
`define CTRL_DIAG_LO    0
`define CTRL_DIAG_HI    1
`define CTRL_PROCESS    2
`define CTRL_COMPAT     3
`define CTRL_COND_WIRED 4
`define CTRL_RESUME     5

// Diagnostic switch encodings
`define DIAG_OFF        2'h0
`define DIAG_STOP       2'h1
`define DIAG_TRAP       2'h2

// Status bit positions
`define ST_TRAP         0
`define ST_STOP         1
`define ST_MCHK         2
`define ST_LOGDONE      3
`define ST_DIAG         4
`define ST_PROGERR      5
`define ST_MATCH        6

// ==============================
// Reset values and fixed figures
`define CTRL_RESET      6'h00
`define MASK_RESET      7'h00
`define TRAP_BASE       16'h0280
`define TRAP_AREA_BYTES 16'h0040
`define LOG_AREA_BYTES  8'h90
`define DIAG_OPCODE     8'h83
`define DIAG_FN_COPYSW  12'h000
`define DIAG_SW_BASE    8'hfc
`define DIAG_SW_COUNT   3'h6
`define MATCH_TPULSE    3'h7

`endif

// ===== hw/logout_mem.v
// Small register-output memory that holds the machine-check logout area.
// Assumes a single writer and reader on pclk; read data lags one cycle.
`timescale 1ns/1ps
`include "maint_trap_regs.vh"

module logout_mem (
	// Clock
	input  wire       pclk,
	// Write port
	input  wire       wr_en,
	input  wire [7:0] wr_addr,
	input  wire [7:0] wr_data,
	// Read port
	input  wire [7:0] rd_addr,
	output reg  [7:0] rd_data
);

	reg [7:0] mem [0:143];

	// ==============================
	// Storage
	// No reset: contents are only meaningful after a logout
	always @(posedge pclk) begin
		if (wr_en && wr_addr < `LOG_AREA_BYTES)
			mem[wr_addr] <= wr_data;
		if (rd_addr < `LOG_AREA_BYTES)
			rd_data <= mem[rd_addr];
		else
			rd_data <= 8'h00;
	end

endmodule

// ===== hw/maint_trap_panel.v
// Maintenance trap, machine-check logout, diagnose and test-panel logic.
// Assumes APB on pclk; panel inputs synchronous except the condition hub.
//
// Functional notes
// - Trap switch: positive condition enters trap
// - Trap branches to 64-byte area at 0280
// - Process position: machine check takes trap
// - Logout status into first 144 storage bytes
// - Logged area sent to printer-keyboard
// - Compatibility mode halts after logout
// - Opcode 83 decoded, displacement selects function
// - Copy six diagnostic switch bytes to storage
// - Three-input AND, true and complement outputs
// - Unconnected AND inputs read as positive
// - Compatibility program error code printed
// - Condition pulse stops or traps by switch
// - Match output at T7 on address equality
// - Unwired condition input stops every cycle
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
`include "maint_trap_regs.vh"

module maint_trap_panel (
	// Clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	// Test panel hubs
	input  wire        condition_input_hub,
	input  wire [2:0]  and_in,
	input  wire [2:0]  and_in_plugged,
	output reg         and_out_pos,
	output reg         and_out_neg,
	input  wire        match_gate,
	output reg         match_out,
	// Processor side
	input  wire [15:0] storage_addr,
	input  wire [2:0]  timing_pulse,
	input  wire        machine_check,
	input  wire        op_valid,
	input  wire        op_invalid,
	input  wire [7:0]  op_code,
	input  wire [11:0] function_select_displacement,
	input  wire [7:0]  status_byte,
	output reg         clock_stop,
	output reg         trap_req,
	output reg  [15:0] trap_addr,
	output reg         ps_wr_en,
	output reg  [15:0] ps_wr_addr,
	output reg  [7:0]  ps_wr_data,
	// Printer-keyboard byte stream
	output reg         prt_valid,
	output reg  [7:0]  prt_data,
	input  wire        prt_ready,
	// Interrupt
	output wire        irq
);

	// ==============================
	// Local state
	localparam S_IDLE = 3'h0;
	localparam S_LOG  = 3'h1;
	localparam S_PRT  = 3'h2;
	localparam S_HALT = 3'h3;
	localparam S_DIAG = 3'h4;
	localparam S_ERR  = 3'h5;

	reg [5:0]  ctrl_reg;
	reg [6:0]  status_reg;
	reg [6:0]  mask_reg;
	reg [47:0] diagsw_reg;
	reg [15:0] match_addr_reg;
	reg [7:0]  errcode_reg;
	reg [2:0]  state_reg;
	reg [7:0]  idx_reg;
	reg        cond_s1_reg;
	reg        cond_s2_reg;
	reg        cond_prev_reg;
	reg        mchk_prev_reg;
	reg        prt_wait_reg;
	reg        log_rd_pend_reg;
	reg [6:0]  ev;

	wire       wr_acc = psel && penable && pwrite;
	wire [1:0] diag_sel = ctrl_reg[`CTRL_DIAG_HI:`CTRL_DIAG_LO];
	wire       cond_rise = cond_s2_reg && !cond_prev_reg;
	wire [7:0] log_rd_data;
	reg  [7:0] log_rd_addr;

	// Byte n of the diagnostic switch bank
	function [7:0] sw_byte;
		input [47:0] bank;
		input [2:0]  n;
		begin
			sw_byte = bank[{n, 3'h0} +: 8];
		end
	endfunction

	// Register address decode
	function is_reg;
		input [11:0] a;
		input [11:0] ofs;
		begin
			is_reg = (a == ofs);
		end
	endfunction

	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign irq     = |(status_reg & mask_reg);

	// ==============================
	// Condition hub synchroniser
	// Second stage only feeds the edge detector, first stage stays private
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cond_s1_reg   <= 1'b0;
			cond_s2_reg   <= 1'b0;
			cond_prev_reg <= 1'b0;
			mchk_prev_reg <= 1'b0;
		end else begin
			cond_s1_reg   <= condition_input_hub;
			cond_s2_reg   <= cond_s1_reg;
			cond_prev_reg <= cond_s2_reg;
			mchk_prev_reg <= machine_check;
		end
	end

	// ==============================
	// Test panel AND and address match
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			and_out_pos <= 1'b0;
			and_out_neg <= 1'b1;
			match_out   <= 1'b0;
		end else begin
			and_out_pos <= &(and_in | ~and_in_plugged);
			and_out_neg <= ~&(and_in | ~and_in_plugged);
			match_out   <= match_gate && (timing_pulse == `MATCH_TPULSE) &&
			               (storage_addr == match_addr_reg);
		end
	end

	// ==============================
	// Logout memory
	logout_mem u_log (
		.pclk    (pclk),
		.wr_en   (state_reg == S_LOG),
		.wr_addr (idx_reg),
		.wr_data (status_byte),
		.rd_addr (log_rd_addr),
		.rd_data (log_rd_data)
	);

	always @* begin
		log_rd_addr = idx_reg;
		// Setup cycle preloads byte 0; printing keeps the port to itself
		if (psel && !pwrite && is_reg(paddr, `OFS_LOG_DATA) && state_reg != S_PRT)
			log_rd_addr = 8'h00;
	end

	// ==============================
	// Trap, logout, diagnose sequencer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg       <= S_IDLE;
			idx_reg         <= 8'h00;
			clock_stop      <= 1'b0;
			trap_req        <= 1'b0;
			trap_addr       <= 16'h0000;
			ps_wr_en        <= 1'b0;
			ps_wr_addr      <= 16'h0000;
			ps_wr_data      <= 8'h00;
			prt_valid       <= 1'b0;
			prt_data        <= 8'h00;
			prt_wait_reg    <= 1'b0;
			log_rd_pend_reg <= 1'b0;
			errcode_reg     <= 8'h00;
			ev              <= 7'h00;
		end else begin
			ev         <= 7'h00;
			trap_req   <= 1'b0;
			ps_wr_en   <= 1'b0;
			if (match_out)
				ev[`ST_MATCH] <= 1'b1;
			if (prt_valid && prt_ready)
				prt_valid <= 1'b0;
			case (state_reg)
			S_IDLE: begin
				clock_stop <= 1'b0;
				if (machine_check && !mchk_prev_reg && ctrl_reg[`CTRL_PROCESS]) begin
					trap_req       <= 1'b1;
					trap_addr      <= `TRAP_BASE;
					ev[`ST_MCHK]   <= 1'b1;
					idx_reg        <= 8'h00;
					state_reg      <= S_LOG;
				end else if ((diag_sel == `DIAG_STOP || diag_sel == `DIAG_TRAP) &&
				             (!ctrl_reg[`CTRL_COND_WIRED] || cond_rise)) begin
					clock_stop <= 1'b1;
					if (diag_sel == `DIAG_TRAP) begin
						trap_req     <= 1'b1;
						trap_addr    <= `TRAP_BASE;
						ev[`ST_TRAP] <= 1'b1;
					end else begin
						ev[`ST_STOP] <= 1'b1;
					end
				end else if (op_valid && op_code == `DIAG_OPCODE &&
				             function_select_displacement == `DIAG_FN_COPYSW) begin
					idx_reg   <= 8'h00;
					state_reg <= S_DIAG;
				end else if (op_valid && op_invalid && ctrl_reg[`CTRL_COMPAT]) begin
					errcode_reg     <= op_code;
					ev[`ST_PROGERR] <= 1'b1;
					state_reg       <= S_ERR;
				end
			end
			S_LOG: begin
				// Status bytes land in the low protected region
				idx_reg <= idx_reg + 8'h01;
				if (idx_reg == `LOG_AREA_BYTES - 8'h01) begin
					idx_reg         <= 8'h00;
					log_rd_pend_reg <= 1'b0;
					prt_wait_reg    <= 1'b0;
					state_reg       <= S_PRT;
				end
			end
			S_PRT: begin
				// One cycle of memory latency before each printed byte
				if (!prt_valid && !prt_wait_reg && !log_rd_pend_reg) begin
					log_rd_pend_reg <= 1'b1;
				end else if (log_rd_pend_reg) begin
					log_rd_pend_reg <= 1'b0;
					prt_valid       <= 1'b1;
					prt_data        <= log_rd_data;
					prt_wait_reg    <= 1'b1;
				end else if (prt_valid && prt_ready) begin
					prt_wait_reg <= 1'b0;
					if (idx_reg == `LOG_AREA_BYTES - 8'h01) begin
						ev[`ST_LOGDONE] <= 1'b1;
						state_reg <= ctrl_reg[`CTRL_COMPAT] ? S_HALT : S_IDLE;
					end
					idx_reg <= idx_reg + 8'h01;
				end
			end
			S_HALT: begin
				clock_stop <= 1'b1;
				if (wr_acc && is_reg(paddr, `OFS_CTRL) && pwdata[`CTRL_RESUME])
					state_reg <= S_IDLE;
			end
			S_DIAG: begin
				ps_wr_en   <= 1'b1;
				ps_wr_addr <= {8'h00, `DIAG_SW_BASE} + {8'h00, idx_reg};
				ps_wr_data <= sw_byte(diagsw_reg, idx_reg[2:0]);
				idx_reg    <= idx_reg + 8'h01;
				if (idx_reg[2:0] == `DIAG_SW_COUNT - 3'h1) begin
					ev[`ST_DIAG] <= 1'b1;
					state_reg    <= S_IDLE;
				end
			end
			S_ERR: begin
				if (!prt_valid) begin
					prt_valid <= 1'b1;
					prt_data  <= errcode_reg;
					state_reg <= S_IDLE;
				end
			end
			default: state_reg <= S_IDLE;
			endcase
		end
	end

	// ==============================
	// Software registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg       <= `CTRL_RESET;
			status_reg     <= 7'h00;
			mask_reg       <= `MASK_RESET;
			diagsw_reg     <= 48'h0;
			match_addr_reg <= 16'h0000;
		end else begin
			// Set wins over a simultaneous write-one clear
			if (wr_acc && is_reg(paddr, `OFS_STATUS))
				status_reg <= (status_reg & ~pwdata[6:0]) | ev;
			else
				status_reg <= status_reg | ev;
			if (wr_acc && is_reg(paddr, `OFS_CTRL))
				ctrl_reg <= {1'b0, pwdata[4:0]};
			if (wr_acc && is_reg(paddr, `OFS_MASK))
				mask_reg <= pwdata[6:0];
			if (wr_acc && is_reg(paddr, `OFS_DIAGSW_LO))
				diagsw_reg[31:0] <= pwdata;
			if (wr_acc && is_reg(paddr, `OFS_DIAGSW_HI))
				diagsw_reg[47:32] <= pwdata[15:0];
			if (wr_acc && is_reg(paddr, `OFS_MATCH_ADDR))
				match_addr_reg <= pwdata[15:0];
		end
	end

	always @* begin
		case (paddr)
		`OFS_CTRL:       prdata = {26'h0, ctrl_reg};
		`OFS_STATUS:     prdata = {25'h0, status_reg};
		`OFS_MASK:       prdata = {25'h0, mask_reg};
		`OFS_TRAPADDR:   prdata = {13'h0, state_reg, trap_addr};
		`OFS_DIAGSW_LO:  prdata = diagsw_reg[31:0];
		`OFS_DIAGSW_HI:  prdata = {16'h0, diagsw_reg[47:32]};
		`OFS_MATCH_ADDR: prdata = {16'h0, match_addr_reg};
		`OFS_ERRCODE:    prdata = {24'h0, errcode_reg};
		`OFS_LOG_DATA:   prdata = {24'h0, log_rd_data};
		default:         prdata = 32'h0;
		endcase
	end

endmodule

// ===== test/maint_trap_panel_chk.sv
// Port checker for the maintenance trap and test panel block.
// Assumes binding onto maint_trap_panel; one clock, async low reset.
`timescale 1ns/1ps

// ====================
// Checker
module maint_chk (
	input wire        pclk,
	input wire        presetn,
	input wire [2:0]  and_in,
	input wire [2:0]  and_in_plugged,
	input wire        and_out_pos,
	input wire        and_out_neg,
	input wire        match_gate,
	input wire [2:0]  timing_pulse,
	input wire        match_out,
	input wire        trap_req,
	input wire [15:0] trap_addr,
	input wire        ps_wr_en,
	input wire [15:0] ps_wr_addr,
	input wire        prt_valid,
	input wire [7:0]  prt_data,
	input wire        prt_ready
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_and_true: assert property ($past(presetn) |->
		and_out_pos == &($past(and_in) | ~$past(and_in_plugged)))
		else $error("and output wrong");
	chk_and_comp: assert property (and_out_neg != and_out_pos)
		else $error("and complement wrong");
	chk_trap_base: assert property (trap_req |-> trap_addr == 16'h0280)
		else $error("trap address wrong");
	chk_match_t7: assert property (match_out |->
		$past(timing_pulse) == 3'h7 && $past(match_gate))
		else $error("match outside gated T7");
	chk_diag_six: assert property ($rose(ps_wr_en) && ps_wr_addr == 16'h00fc |->
		ps_wr_en [*6] ##1 !ps_wr_en)
		else $error("diagnose burst length wrong");
	chk_diag_step: assert property (ps_wr_en && $past(ps_wr_en) && ps_wr_addr > 16'h00fc |->
		ps_wr_addr == $past(ps_wr_addr) + 16'h0001)
		else $error("diagnose address step wrong");
	chk_prt_valid: assert property (prt_valid && !prt_ready |=> prt_valid)
		else $error("print byte withdrawn");
	chk_prt_data: assert property (prt_valid && !prt_ready |=> $stable(prt_data))
		else $error("print byte changed");
	cover property (trap_req);
	cover property (ps_wr_en);
	cover property (match_out);
	cover property (prt_valid && prt_ready);
endmodule

bind maint_trap_panel maint_chk u_chk (.*);

// ===== test/prt_keyboard.sv
// Printer-keyboard model on the far side of the print byte stream.
// Assumes pclk; slow mode accepts one byte in four cycles.
`timescale 1ns/1ps

// ====================
// Printer model
module prt_keyboard (
	input  wire       pclk,
	input  wire       slow,
	input  wire       prt_valid,
	input  wire [7:0] prt_data,
	output reg        prt_ready,
	output int        got,
	output reg  [7:0] last
);
	reg [1:0] cnt = 2'h0;
	initial begin
		prt_ready = 1'b0;
		got = 0;
		last = 8'h00;
	end
	always @(posedge pclk) begin
		if (prt_valid && prt_ready) begin
			got <= got + 1;
			last <= prt_data;
		end
		cnt <= cnt + 2'h1;
		prt_ready <= slow ? (cnt == 2'h3) : 1'b1;
	end
endmodule

// ===== test/test_maint_trap_panel.sv
// Self-checking bench for the maintenance trap and test panel block.
// Assumes the design header and a printer model on the print stream.
`timescale 1ns/1ps
`include "maint_trap_regs.vh"

// ====================
// Bench
module test_maint_trap_panel;
	reg         pclk = 1'b0, presetn, psel, penable, pwrite, slow;
	reg  [11:0] paddr, function_select_displacement;
	reg  [31:0] pwdata, q;
	wire [31:0] prdata;
	wire        pready, pslverr, and_out_pos, and_out_neg, match_out, irq;
	reg         condition_input_hub, match_gate, machine_check;
	reg         op_valid, op_invalid;
	reg  [2:0]  and_in, and_in_plugged, timing_pulse;
	reg  [15:0] storage_addr;
	reg  [7:0]  op_code, status_byte;
	wire        clock_stop, trap_req, ps_wr_en, prt_valid, prt_ready;
	wire [15:0] trap_addr, ps_wr_addr;
	wire [7:0]  ps_wr_data, prt_data, last;
	reg  [7:0]  sw [0:5];
	int         got, err_count = 0, compares = 0, i, n0, n1;
	int         n_trap = 0, n_stop = 0, n_match = 0, n_ps = 0;

	maint_trap_panel DUT (.*);
	prt_keyboard PK (.*);

	always #20 pclk = ~pclk;
	always @(posedge pclk) begin
		n_trap <= n_trap + trap_req;
		n_stop <= n_stop + clock_stop;
		n_match <= n_match + match_out;
		n_ps <= n_ps + ps_wr_en;
		if (ps_wr_en)
			sw[ps_wr_addr - 16'h00fc] <= ps_wr_data;
	end

	task end_of_test;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input [31:0] s, input [31:0] e, input string nm);
		compares++;
		if (s !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// Starts just after an edge; one idle cycle follows each transfer
	task apb(input w, input [11:0] a, input [31:0] d);
		int n;
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		n = 0;
		do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin err_count++; end_of_test; end
		q = prdata;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge pclk);
	endtask
	task rd(input [11:0] a, input [31:0] e, input string nm);
		apb(1'b0, a, 0);
		chk(q, e, nm);
	endtask
	task op(input [7:0] c, input bad);
		op_code <= c; op_invalid <= bad; op_valid <= 1'b1;
		cyc(1);
		op_valid <= 1'b0; op_invalid <= 1'b0;
		cyc(14);
	endtask

	initial begin
		{psel, penable, pwrite, paddr, pwdata, function_select_displacement} = 0;
		{condition_input_hub, match_gate, machine_check, op_valid, op_invalid} = 0;
		{and_in, and_in_plugged, timing_pulse, storage_addr, op_code} = 0;
		status_byte = 8'h5a; slow = 1'b1; presetn = 1'b0;
		cyc(20);
		presetn <= 1'b1;
		rd(`OFS_CTRL, 0, "ctrl");
		rd(`OFS_MASK, 0, "mask");
		rd(12'h030, 0, "unmapped");
		chk(pslverr, 0, "pslverr");
		for (i = 0; i < 64; i++) begin
			{and_in_plugged, and_in} <= i[5:0];
			cyc(2);
			chk(and_out_pos, &(and_in | ~and_in_plugged), "and_pos");
			chk(and_out_neg, ~&(and_in | ~and_in_plugged), "and_neg");
		end
		apb(1'b1, `OFS_CTRL, 32'h12);
		n0 = n_trap;
		condition_input_hub <= 1'b1;
		cyc(1);
		chk(clock_stop, 0, "early stop");
		cyc(6);
		chk(n_trap - n0, 1, "cond trap");
		apb(1'b0, `OFS_TRAPADDR, 0);
		chk(q[15:0], 16'h0280, "trap_addr");
		chk(trap_addr, 16'h0280, "trap_addr pin");
		condition_input_hub <= 1'b0;
		apb(1'b1, `OFS_CTRL, 32'h11);
		n1 = n_stop;
		condition_input_hub <= 1'b1;
		cyc(6);
		chk(n_stop > n1 && n_trap == n0 + 1, 1, "cond stop");
		apb(1'b1, `OFS_CTRL, 32'h01);
		n1 = n_stop;
		cyc(8);
		chk(n_stop - n1 > 5, 1, "unwired stop");
		apb(1'b1, `OFS_CTRL, 0);
		condition_input_hub <= 1'b0;
		rd(`OFS_STATUS, 32'h3, "status");
		chk(irq, 0, "irq masked");
		apb(1'b1, `OFS_MASK, 1);
		chk(irq, 1, "irq");
		apb(1'b1, `OFS_STATUS, 1);
		rd(`OFS_STATUS, 32'h2, "w1c");
		chk(irq, 0, "irq cleared");
		apb(1'b1, `OFS_DIAGSW_LO, 32'h44332211);
		apb(1'b1, `OFS_DIAGSW_HI, 32'h6655);
		n0 = n_ps;
		op(8'h82, 1'b0);
		chk(n_ps, n0, "other opcode");
		function_select_displacement <= 12'h004;
		op(8'h83, 1'b0);
		chk(n_ps, n0, "other function");
		function_select_displacement <= 12'h000;
		op(8'h83, 1'b0);
		chk(n_ps - n0, 6, "diag count");
		for (i = 0; i < 6; i++)
			chk(sw[i], 8'h11 * (i + 1), "diag byte");
		rd(`OFS_STATUS, 32'h12, "diag status");
		apb(1'b1, `OFS_MATCH_ADDR, 32'h1234);
		storage_addr <= 16'h1234;
		n0 = n_match;
		for (i = 0; i < 32; i++) begin
			match_gate <= (i < 16);
			timing_pulse <= i[2:0];
			cyc(1);
		end
		cyc(2);
		chk(n_match - n0, 2, "match count");
		apb(1'b1, `OFS_STATUS, 32'h7f);
		apb(1'b1, `OFS_CTRL, 32'h0c);
		n0 = n_trap;
		n1 = got;
		machine_check <= 1'b1;
		cyc(2);
		machine_check <= 1'b0;
		q = 0;
		for (i = 0; i < 3000 && q[`ST_LOGDONE] !== 1'b1; i++)
			apb(1'b0, `OFS_STATUS, 0);
		if (i >= 3000) begin err_count++; end_of_test; end
		chk(n_trap - n0, 1, "mchk trap");
		chk(got - n1, 144, "log bytes");
		chk(last, 8'h5a, "log byte");
		rd(`OFS_LOG_DATA, 32'h5a, "log data");
		chk(clock_stop, 1, "halted");
		apb(1'b1, `OFS_CTRL, 32'h28);
		cyc(2);
		chk(clock_stop, 0, "resumed");
		n1 = got;
		op(8'h3c, 1'b1);
		chk(got - n1, 1, "error print");
		chk(last, 8'h3c, "error code");
		rd(`OFS_ERRCODE, 32'h3c, "errcode");
		end_of_test;
	end
	initial begin
		#4000000;
		err_count++;
		end_of_test;
	end
endmodule
